// ---- common/stack_pkg.sv ----
// Package for the per-processor stack engine: widths, operation codes, states.
// Assumes a single clock domain and a synchronous single-port RAM.
`default_nettype none
package stack_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int OFS_W = 8;
    localparam int NUM_PROC = 4;
    localparam int PROC_W = 2;
    localparam logic [15:0] BASE_RST = 16'h0000;
    localparam logic [7:0] DATA_OFS_RST = 8'h00;
    localparam logic [7:0] RET_OFS_RST = 8'hFF;
    localparam logic [7:0] TOS_RST = 8'h00;
    localparam logic [15:0] IP_RST = 16'h0000;
    localparam logic [7:0] OFS_ONE = 8'h01;

    typedef enum logic [2:0] {
        OP_PUSH = 3'h0,
        OP_POP = 3'h1,
        OP_CALL = 3'h2,
        OP_RET = 3'h3,
        OP_RPUSH = 3'h4,
        OP_RPOP = 3'h5,
        OP_SETBP = 3'h6,
        OP_SETIP = 3'h7
    } stack_op_t;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_STEP1 = 6'b000010,
        ST_STEP2 = 6'b000100,
        ST_STEP3 = 6'b001000,
        ST_STEP4 = 6'b010000,
        ST_DONE = 6'b100000
    } engine_state_t;
endpackage : stack_pkg
`default_nettype wire

// ---- rtl/page_addr.sv ----
// Base page address former: base plus zero-extended offset.
// Assumes base and offset come from the engine's per-processor registers.
`timescale 1ns/100ps
`default_nettype none
module page_addr
    import stack_pkg::*;
(
    input wire logic [ADDR_W-1:0] base,  // Base page address
    input wire logic [OFS_W-1:0] ofs,    // Offset within page
    output logic [ADDR_W-1:0] addr       // Resulting RAM address
);
    // Adding in 16 bits wraps at the top of RAM
    assign addr = base + {{(ADDR_W-OFS_W){1'b0}}, ofs};
endmodule : page_addr
`default_nettype wire

// ---- rtl/stack_engine.sv ----
// Stack engine: push, pop, call and return over base pages in shared RAM.
// Assumes RAM with one-cycle registered read data and single-cycle writes.
// What this block does
// - Data stack byte wide, operands top and second
// - Base page at most 256 bytes holds stacks
// - Each processor has its own base page pointer, all 0000 after reset
// - Top in register, second at base plus offset
// - Second entry always read from RAM
// - Data stack grows upward, tracked by offset
// - Push: increment, store old top, load new
// - Pop: deliver top, reload from RAM, decrement
// - Return stack grows downward, own offset register
// - Call: store high, decrement, low, decrement, jump
// - Return: increment, load low, increment, load high
// - Return stack also holds temporary bytes
// - Base page pointer is sixteen bits
// - Both stack offsets are eight bits
// - Instruction pointer sixteen bits, saved as bytes
`timescale 1ns/100ps
`default_nettype none
module stack_engine
    import stack_pkg::*;
#(
    parameter int PROCS = NUM_PROC
)
(
    input wire logic clk,                         // 10 MHz core clock
    input wire logic rst_b,                       // Synchronous reset, active low
    input wire logic op_valid,                    // Operation request
    output logic op_ready,                        // Engine idle, request taken
    input wire logic [2:0] op_code,               // stack_op_t operation
    input wire logic [PROC_W-1:0] op_proc,        // Logical processor select
    input wire logic [DATA_W-1:0] op_data,        // Byte to push
    input wire logic [ADDR_W-1:0] op_addr,        // Call target or new base
    output logic done,                            // One-cycle completion pulse
    output logic [DATA_W-1:0] pop_data,           // Popped byte
    output logic [DATA_W-1:0] top_of_data_stack,  // Top of selected processor
    output logic [ADDR_W-1:0] instruction_pointer,// Pointer of selected processor
    output logic [ADDR_W-1:0] ram_addr,           // RAM address
    output logic ram_we,                          // RAM write strobe
    output logic ram_re,                          // RAM read strobe
    output logic [DATA_W-1:0] ram_wdata,          // RAM write data
    input wire logic [DATA_W-1:0] ram_rdata       // RAM read data, one cycle later
);
    // Per-processor register sets
    logic [ADDR_W-1:0] base_page_pointer [PROCS];
    logic [OFS_W-1:0] data_stack_offset [PROCS];
    logic [OFS_W-1:0] return_stack_offset [PROCS];
    logic [DATA_W-1:0] tos_r [PROCS];
    logic [ADDR_W-1:0] ip_r [PROCS];

    engine_state_t state_r;
    stack_op_t op_r;
    logic [PROC_W-1:0] proc_r;
    logic [DATA_W-1:0] data_r;
    logic [ADDR_W-1:0] target_r;
    logic [OFS_W-1:0] cur_ofs;
    logic [ADDR_W-1:0] page_adr;

    assign op_ready = (state_r == ST_IDLE);
    assign top_of_data_stack = tos_r[proc_r];
    assign instruction_pointer = ip_r[proc_r];

    // Offset of the step; a return pop reads the slot above, pairing with push
    always_comb
    begin
        cur_ofs = (op_r == OP_PUSH || op_r == OP_POP) ? data_stack_offset[proc_r] :
            (op_r == OP_RPOP) ? return_stack_offset[proc_r] + OFS_ONE :
            return_stack_offset[proc_r];
    end

    // Own base page pointer per processor; all reset to 0000, so they share a page until SETBP sets them apart
    page_addr u_page_addr
    (
        .base(base_page_pointer[proc_r]),
        .ofs(cur_ofs),
        .addr(page_adr)
    );

    // RAM strobes per step; second entry is only ever a RAM access
    always_comb
    begin
        ram_addr = page_adr;
        ram_we = 1'b0;
        ram_re = 1'b0;
        ram_wdata = 8'h00;
        case (state_r)
            ST_STEP2:
                if (op_r == OP_PUSH)
                begin
                    ram_we = 1'b1;
                    ram_wdata = tos_r[proc_r];
                end
                else if (op_r == OP_RET)
                    ram_re = 1'b1;
            ST_STEP1:
                if (op_r == OP_CALL)
                begin
                    ram_we = 1'b1;
                    ram_wdata = ip_r[proc_r][15:8];
                end
                else if (op_r == OP_RPUSH)
                begin
                    ram_we = 1'b1;
                    ram_wdata = data_r;
                end
                else if (op_r == OP_POP || op_r == OP_RPOP)
                    ram_re = 1'b1;
            ST_STEP3:
                if (op_r == OP_CALL)
                begin
                    ram_we = 1'b1;
                    ram_wdata = ip_r[proc_r][7:0];
                end
            ST_STEP4:
                if (op_r == OP_RET)
                    ram_re = 1'b1;
            default:
                ram_re = 1'b0;
        endcase
    end

    // Sequencer: request latch and step walk
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            state_r <= ST_IDLE;
            op_r <= OP_PUSH;
            proc_r <= '0;
            data_r <= 8'h00;
            target_r <= 16'h0000;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    if (op_valid)
                    begin
                        op_r <= stack_op_t'(op_code);
                        proc_r <= op_proc;
                        data_r <= op_data;
                        target_r <= op_addr;
                        state_r <= ST_STEP1;
                    end
                end
                ST_STEP1:
                    if (op_r == OP_SETBP || op_r == OP_SETIP)
                        state_r <= ST_DONE;
                    else
                        state_r <= ST_STEP2;
                ST_STEP2:
                    if (op_r == OP_CALL || op_r == OP_RET)
                        state_r <= ST_STEP3;
                    else
                        state_r <= ST_DONE;
                ST_STEP3:
                    state_r <= ST_STEP4;
                ST_STEP4:
                    state_r <= ST_DONE;
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // Architectural register updates, one step at a time
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < PROCS; i++)
            begin
                base_page_pointer[i] <= BASE_RST;
                data_stack_offset[i] <= DATA_OFS_RST;
                return_stack_offset[i] <= RET_OFS_RST;
                tos_r[i] <= TOS_RST;
                ip_r[i] <= IP_RST;
            end
            pop_data <= 8'h00;
            done <= 1'b0;
        end
        else
        begin
            done <= (state_r == ST_DONE);
            case (state_r)
                ST_STEP1:
                    case (op_r)
                        // Data stack grows upward, wraps in eight bits
                        OP_PUSH: data_stack_offset[proc_r] <= data_stack_offset[proc_r] + OFS_ONE;
                        OP_POP: pop_data <= tos_r[proc_r];
                        OP_RET: return_stack_offset[proc_r] <= return_stack_offset[proc_r] + OFS_ONE;
                        OP_SETBP: base_page_pointer[proc_r] <= target_r;
                        OP_SETIP: ip_r[proc_r] <= target_r;
                        OP_RPUSH: return_stack_offset[proc_r] <= return_stack_offset[proc_r] - OFS_ONE;
                        default: ;
                    endcase
                ST_STEP2:
                    case (op_r)
                        OP_PUSH: tos_r[proc_r] <= data_r;
                        OP_POP:
                        begin
                            tos_r[proc_r] <= ram_rdata;
                            data_stack_offset[proc_r] <= data_stack_offset[proc_r] - OFS_ONE;
                        end
                        OP_RPOP:
                        begin
                            pop_data <= ram_rdata;
                            return_stack_offset[proc_r] <= return_stack_offset[proc_r] + OFS_ONE;
                        end
                        // Return stack grows downward
                        OP_CALL: return_stack_offset[proc_r] <= return_stack_offset[proc_r] - OFS_ONE;
                        default: ;
                    endcase
                ST_STEP3:
                    if (op_r == OP_CALL)
                        return_stack_offset[proc_r] <= return_stack_offset[proc_r] - OFS_ONE;
                    else if (op_r == OP_RET)
                    begin
                        ip_r[proc_r][7:0] <= ram_rdata;
                        return_stack_offset[proc_r] <= return_stack_offset[proc_r] + OFS_ONE;
                    end
                ST_STEP4:
                    if (op_r == OP_CALL)
                        ip_r[proc_r] <= target_r;
                ST_DONE:
                    if (op_r == OP_RET)
                        ip_r[proc_r][15:8] <= ram_rdata;
                default: ;
            endcase
        end
    end

    // Push writes the old top one step after the offset moves up
    property p_push_order;
        @(posedge clk) disable iff (!rst_b)
        (state_r == ST_STEP2 && op_r == OP_PUSH) |-> ram_we && ram_wdata == $past(tos_r[proc_r])
            && data_stack_offset[proc_r] == $past(data_stack_offset[proc_r]) + OFS_ONE;
    endproperty
    a_push_order: assert property (p_push_order) else $error("push order wrong");
    // Read data lands a cycle after the strobe and is loaded on the next edge
    property p_pop_reload;
        @(posedge clk) disable iff (!rst_b)
        (state_r == ST_STEP1 && op_r == OP_POP) |-> ram_re ##2 tos_r[proc_r] == $past(ram_rdata);
    endproperty
    a_pop_reload: assert property (p_pop_reload) else $error("pop reload wrong");
    property p_pop_dec;
        @(posedge clk) disable iff (!rst_b)
        (state_r == ST_STEP2 && op_r == OP_POP) |=>
            data_stack_offset[proc_r] == $past(data_stack_offset[proc_r]) - OFS_ONE;
    endproperty
    a_pop_dec: assert property (p_pop_dec) else $error("pop decrement wrong");
    property p_addr_form;
        @(posedge clk) disable iff (!rst_b)
        (ram_we || ram_re) |-> ram_addr == base_page_pointer[proc_r] + {8'h00, cur_ofs};
    endproperty
    a_addr_form: assert property (p_addr_form) else $error("address form wrong");
    property p_call_high;
        @(posedge clk) disable iff (!rst_b)
        (state_r == ST_STEP1 && op_r == OP_CALL) |-> ram_we && ram_wdata == ip_r[proc_r][15:8]
            ##2 ram_we && ram_wdata == ip_r[proc_r][7:0];
    endproperty
    a_call_high: assert property (p_call_high) else $error("call save wrong");
    property p_call_len;
        @(posedge clk) disable iff (!rst_b)
        (state_r == ST_IDLE && op_valid && op_code == OP_CALL) |=> ##5 done;
    endproperty
    a_call_len: assert property (p_call_len) else $error("call length wrong");
    property p_ret_reads;
        @(posedge clk) disable iff (!rst_b)
        (state_r == ST_STEP2 && op_r == OP_RET) |-> ram_re ##2 ram_re;
    endproperty
    a_ret_reads: assert property (p_ret_reads) else $error("return reads wrong");
    property p_ret_ofs;
        @(posedge clk) disable iff (!rst_b)
        (state_r == ST_IDLE && op_valid && op_code == OP_RET) |=> ##5
            return_stack_offset[proc_r] == $past(return_stack_offset[proc_r], 5) + 8'h02;
    endproperty
    a_ret_ofs: assert property (p_ret_ofs) else $error("return offset wrong");
    property p_push_dir;
        @(posedge clk) disable iff (!rst_b)
        (state_r == ST_STEP1 && op_r == OP_RPUSH) |=>
            return_stack_offset[proc_r] == $past(return_stack_offset[proc_r]) - OFS_ONE;
    endproperty
    a_push_dir: assert property (p_push_dir) else $error("return push direction wrong");
endmodule : stack_engine
`default_nettype wire

// ---- testbench/ram_model.sv ----
// Partner model: shared single-port RAM that holds every base page.
// Assumes one-cycle strobes on clk; read data is valid one cycle after a read.
`timescale 1ns/100ps
`default_nettype none
module ram_model
(
    input wire logic clk,              // Core clock
    input wire logic [15:0] ram_addr,  // Byte address
    input wire logic ram_we,           // Write strobe
    input wire logic ram_re,           // Read strobe
    input wire logic [7:0] ram_wdata,  // Write data
    output logic [7:0] ram_rdata       // Read data, one cycle after strobe
);
    logic [7:0] mem [0:65535];

    // Writes land on the strobe edge
    always @(posedge clk)
    begin
        if (ram_we)
            mem[ram_addr] <= ram_wdata;
    end

    // Outside a read the data toggles, so a late or stale sample shows up
    initial ram_rdata = 8'h5A;
    always @(posedge clk)
    begin
        if (ram_re)
            ram_rdata <= mem[ram_addr];
        else
            ram_rdata <= ~ram_rdata;
    end
endmodule : ram_model
`default_nettype wire

// ---- testbench/stack_engine_tb.sv ----
// Testbench for the stack engine: one task per scenario, RAM checked directly.
// Assumes ram_model as partner; inputs change on the falling edge only.
`timescale 1ns/100ps
`default_nettype none
module stack_engine_tb
    import stack_pkg::*;
;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic op_valid = 1'b0;
    logic [2:0] op_code = 3'h0;
    logic [PROC_W-1:0] op_proc = '0;
    logic [7:0] op_data = 8'h00;
    logic [15:0] op_addr = 16'h0000;
    wire logic op_ready, done, ram_we, ram_re;
    wire logic [7:0] pop_data, top_of_data_stack, ram_wdata, ram_rdata;
    wire logic [15:0] instruction_pointer, ram_addr;
    int bad_count = 0;
    int check_count = 0;

    stack_engine stack_engine_i (.clk, .rst_b, .op_valid, .op_ready, .op_code, .op_proc,
        .op_data, .op_addr, .done, .pop_data, .top_of_data_stack, .instruction_pointer,
        .ram_addr, .ram_we, .ram_re, .ram_wdata, .ram_rdata);
    ram_model ram_model_i (.clk, .ram_addr, .ram_we, .ram_re, .ram_wdata, .ram_rdata);

    // 10 MHz clock
    always #50 clk = ~clk;

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One operation; after the take a stray pop is held one cycle and must be dropped
    task automatic run(input stack_op_t code, input logic [1:0] proc, input logic [15:0] val);
        int n;
        int lat;
        lat = (code == OP_CALL || code == OP_RET) ? 6 : (code >= OP_SETBP) ? 3 : 4;
        @(negedge clk);
        op_code = code;
        op_proc = proc;
        op_data = val[7:0];
        op_addr = val;
        op_valid = 1'b1;
        while (op_ready !== 1'b1)
            @(negedge clk);
        @(negedge clk);
        n = 1;
        op_code = OP_POP;
        @(negedge clk);
        n = 2;
        op_valid = 1'b0;
        while (done !== 1'b1 && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        check("latency", 16'(n), 16'(lat));
    endtask : run

    task automatic t_reset();
        @(negedge clk);
        check("ready", op_ready, 1'b1);
        check("top", top_of_data_stack, TOS_RST);
        check("ip", instruction_pointer, IP_RST);
    endtask : t_reset

    task automatic t_data();
        run(OP_SETBP, 2'h0, 16'h1200);
        run(OP_PUSH, 2'h0, 16'h00A1);
        check("mem 1201", ram_model_i.mem[16'h1201], 8'h00);
        check("top", top_of_data_stack, 8'hA1);
        run(OP_PUSH, 2'h0, 16'h00B2);
        check("mem 1202", ram_model_i.mem[16'h1202], 8'hA1);
        run(OP_POP, 2'h0, 16'h0000);
        check("pop", pop_data, 8'hB2);
        check("top", top_of_data_stack, 8'hA1);
    endtask : t_data

    task automatic t_call();
        run(OP_SETBP, 2'h1, 16'h2000);
        run(OP_SETIP, 2'h1, 16'h3456);
        run(OP_CALL, 2'h1, 16'h789A);
        check("mem 20FF", ram_model_i.mem[16'h20FF], 8'h34);
        check("mem 20FE", ram_model_i.mem[16'h20FE], 8'h56);
        check("ip", instruction_pointer, 16'h789A);
        run(OP_RET, 2'h1, 16'h0000);
        check("ip", instruction_pointer, 16'h3456);
        run(OP_SETIP, 2'h1, 16'hABCD);
        run(OP_CALL, 2'h1, 16'h0100);
        check("mem 20FF", ram_model_i.mem[16'h20FF], 8'hAB);
    endtask : t_call

    // Offsets wrap in eight bits; the sum wraps in sixteen
    task automatic t_wrap();
        ram_model_i.mem[16'hFFF0] = 8'h77;
        ram_model_i.mem[16'h00EF] = 8'h66;
        run(OP_SETBP, 2'h2, 16'hFFF0);
        run(OP_POP, 2'h2, 16'h0000);
        check("top", top_of_data_stack, 8'h77);
        run(OP_POP, 2'h2, 16'h0000);
        check("top", top_of_data_stack, 8'h66);
        check("pop", pop_data, 8'h77);
        run(OP_CALL, 2'h2, 16'h0000);
        check("mem 00EF", ram_model_i.mem[16'h00EF], 8'h00);
    endtask : t_wrap

    task automatic t_isolate();
        run(OP_SETBP, 2'h3, 16'h3000);
        run(OP_PUSH, 2'h3, 16'h0011);
        check("mem 3001", ram_model_i.mem[16'h3001], 8'h00);
        run(OP_SETBP, 2'h0, 16'h1200);
        check("top", top_of_data_stack, 8'hA1);
        check("ip", instruction_pointer, IP_RST);
    endtask : t_isolate

    task automatic t_rstack();
        run(OP_RPUSH, 2'h3, 16'h009C);
        check("mem 30FF", ram_model_i.mem[16'h30FF], 8'h9C);
        run(OP_RPUSH, 2'h3, 16'h008D);
        check("mem 30FE", ram_model_i.mem[16'h30FE], 8'h8D);
        run(OP_RPOP, 2'h3, 16'h0000);
        check("rpop", pop_data, 8'h8D);
        run(OP_RPOP, 2'h3, 16'h0000);
        check("rpop", pop_data, 8'h9C);
        check("top", top_of_data_stack, 8'h11);
        run(OP_CALL, 2'h3, 16'h0000);
        check("mem 30FF", ram_model_i.mem[16'h30FF], 8'h00);
    endtask : t_rstack

    task automatic conclude();
        if (bad_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude

    // Main sequence after a 16-cycle reset
    initial
    begin
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        t_reset();
        t_data();
        t_call();
        t_wrap();
        t_isolate();
        t_rstack();
        conclude();
    end

    // Watchdog: the run needs well under 1000 cycles
    initial
    begin
        #500000;
        bad_count++;
        conclude();
    end
endmodule : stack_engine_tb
`default_nettype wire
